/* File: hw/cssb_pkg.sv */
package cssb_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_OP = 8'h00;
  localparam logic [7:0] ADDR_OPND = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ==========================================================
  // field positions
  localparam int OP_CODE_LSB = 0;
  localparam int OP_IDX_LSB = 8;
  localparam int OP_TWO_WORD_BIT = 12;
  localparam int OP_K_LSB = 16;
  localparam int OPND_RD_LSB = 0;
  localparam int OPND_RR_LSB = 8;
  localparam int OPND_IO_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TAKEN_BIT = 1;
  localparam int STAT_CYC_LSB = 4;

  // status_flags_register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ==========================================================
  // reset values
  localparam logic [31:0] OP_RST = 32'h0000_0000;
  localparam logic [31:0] OPND_RST = 32'h0000_0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // ==========================================================
  // operation codes: compares, then skips, then branches
  localparam logic [4:0] OPC_CMP = 5'h00;
  localparam logic [4:0] OPC_CMP_CARRY = 5'h01;
  localparam logic [4:0] OPC_CMP_IMM = 5'h02;
  localparam logic [4:0] OPC_CMP_SKIP_EQ = 5'h03;
  localparam logic [4:0] OPC_SKIP_REG_CLR = 5'h04;
  localparam logic [4:0] OPC_SKIP_REG_SET = 5'h05;
  localparam logic [4:0] OPC_SKIP_IO_CLR = 5'h06;
  localparam logic [4:0] OPC_SKIP_IO_SET = 5'h07;
  localparam logic [4:0] OPC_BR_FLAG_SET = 5'h08;
  localparam logic [4:0] OPC_BR_FLAG_CLR = 5'h09;
  localparam logic [4:0] OPC_BR_EQ = 5'h0a;
  localparam logic [4:0] OPC_BR_NE = 5'h0b;
  localparam logic [4:0] OPC_BR_CARRY_SET = 5'h0c;
  localparam logic [4:0] OPC_BR_CARRY_CLR = 5'h0d;
  localparam logic [4:0] OPC_BR_SAME_HIGHER = 5'h0e;
  localparam logic [4:0] OPC_BR_LOWER = 5'h0f;
  localparam logic [4:0] OPC_BR_MINUS = 5'h10;
  localparam logic [4:0] OPC_BR_PLUS = 5'h11;
  localparam logic [4:0] OPC_BR_SIGNED_GE = 5'h12;
  localparam logic [4:0] OPC_BR_SIGNED_LT = 5'h13;
  localparam logic [4:0] OPC_BR_HALF_SET = 5'h14;
  localparam logic [4:0] OPC_BR_HALF_CLR = 5'h15;
  localparam logic [4:0] OPC_BR_XFER_SET = 5'h16;
  localparam logic [4:0] OPC_BR_XFER_CLR = 5'h17;
  localparam logic [4:0] OPC_BR_OVF_SET = 5'h18;
  localparam logic [4:0] OPC_BR_OVF_CLR = 5'h19;

  // ==========================================================
  // cycle counts and program counter steps
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [7:0] STEP_NEXT = 8'h01;
  localparam logic [7:0] STEP_SKIP_ONE = 8'h02;
  localparam logic [7:0] STEP_SKIP_TWO = 8'h03;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {CSSB_IDLE, CSSB_EXEC} cssb_state_type;

endpackage

/* File: hw/cssb_cmp_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module cssb_cmp_alu (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cin_i,
  input wire logic keep_z_i,
  input wire logic old_z_i,
  output logic z_o,
  output logic n_o,
  output logic v_o,
  output logic c_o,
  output logic h_o
);

  // ==========================================================
  // subtract without storing the difference
  logic [7:0] diff;

  assign diff = a_i - b_i - {7'h00, cin_i};
  // with carry, zero may only stay set across the chain
  assign z_o = (diff == 8'h00) & (keep_z_i ? old_z_i : 1'b1);
  assign n_o = diff[7];
  assign v_o = (a_i[7] & ~b_i[7] & ~diff[7]) | (~a_i[7] & b_i[7] & diff[7]);
  assign c_o = (~a_i[7] & b_i[7]) | (b_i[7] & diff[7]) | (diff[7] & ~a_i[7]);
  assign h_o = (~a_i[3] & b_i[3]) | (b_i[3] & diff[3]) | (diff[3] & ~a_i[3]);

endmodule
`default_nettype wire

/* File: hw/cssb_unit.sv */
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - equal registers skip next, one to three cycles
// - compares set Z N V C H, one cycle
// - skip when register bit is zero
// - skip when register bit is one
// - skip when io bit is zero
// - skip when io bit is one
// - indexed flag set branches to pc+k+1
// - indexed flag clear branch, one/two cycles
// - equal/not-equal branches test zero flag
// - carry/lower and clear/same-higher test carry
// - minus/plus branches test negative flag
// - signed ge when N xor V zero
// - signed lt when N xor V one
// - half-carry branches test half-carry flag
// - transfer branches test transfer flag
// - overflow branches test overflow flag
module cssb_unit
  import cssb_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PC_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  // ==========================================================
  // functions
  function automatic logic [31:0] apply_strb(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] pc,
                                              input logic [7:0] delta);
    return pc + {{(PC_W-8){delta[7]}}, delta};
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    return (addr == ADDR_W'(ADDR_OP)) || (addr == ADDR_W'(ADDR_OPND)) ||
           (addr == ADDR_W'(ADDR_PC)) || (addr == ADDR_W'(ADDR_FLAGS)) ||
           (addr == ADDR_W'(ADDR_STATUS));
  endfunction

  // ==========================================================
  // reset release
  logic rst_meta_n_ff;
  logic rst_n_ff;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_n_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_n_ff <= 1'b1;
      rst_n_ff <= rst_meta_n_ff;
    end
  end

  // ==========================================================
  // state
  cssb_state_type state_ff;
  logic [31:0] op_ff;
  logic [31:0] opnd_ff;
  logic [PC_W-1:0] pc_ff;
  logic [7:0] status_flags_register_ff;
  logic [PC_W-1:0] res_pc_ff;
  logic [7:0] res_status_flags_register_ff;
  logic [1:0] cnt_ff;
  logic taken_ff;
  logic [1:0] last_cyc_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // ==========================================================
  // write decode
  wire busy = (state_ff == CSSB_EXEC);
  wire wr_fire = awready_ff & s_axi_awvalid_i & wready_ff & s_axi_wvalid_i;
  wire [ADDR_W-1:0] wr_addr = s_axi_awaddr_i;
  wire [31:0] op_wr_word = apply_strb(op_ff, s_axi_wdata_i, s_axi_wstrb_i);
  wire [31:0] flags_wr_word = apply_strb({24'h000000, status_flags_register_ff}, s_axi_wdata_i, s_axi_wstrb_i);
  wire [4:0] s_opc = op_wr_word[OP_CODE_LSB +: 5];
  wire [2:0] s_idx = op_wr_word[OP_IDX_LSB +: 3];
  wire s_two = op_wr_word[OP_TWO_WORD_BIT];
  wire [6:0] s_k = op_wr_word[OP_K_LSB +: 7];
  wire [7:0] rd_val = opnd_ff[OPND_RD_LSB +: 8];
  wire [7:0] rr_val = opnd_ff[OPND_RR_LSB +: 8];
  wire [7:0] io_val = opnd_ff[OPND_IO_LSB +: 8];
  wire op_legal = (s_opc <= OPC_BR_OVF_CLR);
  wire wr_is_op = (wr_addr == ADDR_W'(ADDR_OP));
  wire wr_is_stat = (wr_addr == ADDR_W'(ADDR_STATUS));
  // no change of operands while an operation is in flight
  wire wr_err = !is_mapped(wr_addr) || (busy && !wr_is_stat) || (wr_is_op && !op_legal);
  wire start = wr_fire & wr_is_op & !wr_err;
  wire is_cmp = (s_opc < OPC_CMP_SKIP_EQ);
  wire is_skip = !is_cmp && (s_opc < OPC_BR_FLAG_SET);
  wire is_branch = !is_cmp && !is_skip;

  // ==========================================================
  // compare flags
  logic alu_z;
  logic alu_n;
  logic alu_v;
  logic alu_c;
  logic alu_h;

  cssb_cmp_alu u_alu (
    .a_i(rd_val),
    .b_i(rr_val),
    .cin_i((s_opc == OPC_CMP_CARRY) & status_flags_register_ff[FLAG_C]),
    .keep_z_i(s_opc == OPC_CMP_CARRY),
    .old_z_i(status_flags_register_ff[FLAG_Z]),
    .z_o(alu_z),
    .n_o(alu_n),
    .v_o(alu_v),
    .c_o(alu_c),
    .h_o(alu_h)
  );

  // ==========================================================
  // condition select
  logic s_cond;
  logic s_taken;
  logic [1:0] s_cycles;
  logic [7:0] s_delta;
  logic [7:0] s_status_flags_register;

  always_comb begin
    case (s_opc)
      OPC_CMP_SKIP_EQ: s_cond = (rd_val == rr_val);
      OPC_SKIP_REG_CLR: s_cond = !rd_val[s_idx];
      OPC_SKIP_REG_SET: s_cond = rd_val[s_idx];
      OPC_SKIP_IO_CLR: s_cond = !io_val[s_idx];
      OPC_SKIP_IO_SET: s_cond = io_val[s_idx];
      OPC_BR_FLAG_SET: s_cond = status_flags_register_ff[s_idx];
      OPC_BR_FLAG_CLR: s_cond = !status_flags_register_ff[s_idx];
      OPC_BR_EQ: s_cond = status_flags_register_ff[FLAG_Z];
      OPC_BR_NE: s_cond = !status_flags_register_ff[FLAG_Z];
      OPC_BR_CARRY_SET: s_cond = status_flags_register_ff[FLAG_C];
      OPC_BR_LOWER: s_cond = status_flags_register_ff[FLAG_C];
      OPC_BR_CARRY_CLR: s_cond = !status_flags_register_ff[FLAG_C];
      OPC_BR_SAME_HIGHER: s_cond = !status_flags_register_ff[FLAG_C];
      OPC_BR_MINUS: s_cond = status_flags_register_ff[FLAG_N];
      OPC_BR_PLUS: s_cond = !status_flags_register_ff[FLAG_N];
      OPC_BR_SIGNED_GE: s_cond = !(status_flags_register_ff[FLAG_N] ^ status_flags_register_ff[FLAG_V]);
      OPC_BR_SIGNED_LT: s_cond = status_flags_register_ff[FLAG_N] ^ status_flags_register_ff[FLAG_V];
      OPC_BR_HALF_SET: s_cond = status_flags_register_ff[FLAG_H];
      OPC_BR_HALF_CLR: s_cond = !status_flags_register_ff[FLAG_H];
      OPC_BR_XFER_SET: s_cond = status_flags_register_ff[FLAG_T];
      OPC_BR_XFER_CLR: s_cond = !status_flags_register_ff[FLAG_T];
      OPC_BR_OVF_SET: s_cond = status_flags_register_ff[FLAG_V];
      OPC_BR_OVF_CLR: s_cond = !status_flags_register_ff[FLAG_V];
      default: s_cond = 1'b0;
    endcase
    s_taken = s_cond & !is_cmp;
    s_status_flags_register = status_flags_register_ff;
    s_cycles = CYC_ONE;
    s_delta = STEP_NEXT;
    if (is_cmp) begin
      s_status_flags_register[FLAG_Z] = alu_z;
      s_status_flags_register[FLAG_N] = alu_n;
      s_status_flags_register[FLAG_V] = alu_v;
      s_status_flags_register[FLAG_C] = alu_c;
      s_status_flags_register[FLAG_H] = alu_h;
    end else if (is_skip && s_cond) begin
      s_cycles = s_two ? CYC_THREE : CYC_TWO;
      s_delta = s_two ? STEP_SKIP_TWO : STEP_SKIP_ONE;
    end else if (is_branch && s_cond) begin
      s_cycles = CYC_TWO;
      s_delta = {s_k[6], s_k} + STEP_NEXT;
    end
  end

  // ==========================================================
  // registers and execution
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= CSSB_IDLE;
      op_ff <= OP_RST;
      opnd_ff <= OPND_RST;
      pc_ff <= '0;
      status_flags_register_ff <= FLAGS_RST;
      res_pc_ff <= '0;
      res_status_flags_register_ff <= FLAGS_RST;
      cnt_ff <= 2'h0;
      taken_ff <= 1'b0;
      last_cyc_ff <= 2'h0;
    end else begin
      if (wr_fire && !wr_err) begin
        if (wr_is_op) begin
          op_ff <= op_wr_word;
        end
        if (wr_addr == ADDR_W'(ADDR_OPND)) begin
          opnd_ff <= apply_strb(opnd_ff, s_axi_wdata_i, s_axi_wstrb_i);
        end
        if (wr_addr == ADDR_W'(ADDR_PC)) begin
          pc_ff <= PC_W'(apply_strb(32'(pc_ff), s_axi_wdata_i, s_axi_wstrb_i));
        end
        if (wr_addr == ADDR_W'(ADDR_FLAGS)) begin
          status_flags_register_ff <= flags_wr_word[7:0];
        end
      end
      case (state_ff)
        CSSB_IDLE: begin
          if (start) begin
            state_ff <= CSSB_EXEC;
            cnt_ff <= s_cycles;
            res_pc_ff <= pc_step(pc_ff, s_delta);
            res_status_flags_register_ff <= s_status_flags_register;
            taken_ff <= s_taken;
            last_cyc_ff <= s_cycles;
          end
        end
        CSSB_EXEC: begin
          // busy for exactly the counted cycles
          if (cnt_ff == CYC_ONE) begin
            state_ff <= CSSB_IDLE;
            pc_ff <= res_pc_ff;
            status_flags_register_ff <= res_status_flags_register_ff;
          end
          cnt_ff <= cnt_ff - CYC_ONE;
        end
        default: state_ff <= CSSB_IDLE;
      endcase
    end
  end

  // ==========================================================
  // axi4-lite handshakes
  wire aw_take = s_axi_awvalid_i & s_axi_wvalid_i & !awready_ff & !bvalid_ff;
  wire ar_fire = arready_ff & s_axi_arvalid_i;
  wire [ADDR_W-1:0] ra = s_axi_araddr_i;
  wire [31:0] stat_word = {26'h0, last_cyc_ff, 2'h0, taken_ff, busy};
  wire [31:0] rd_mux = (ra == ADDR_W'(ADDR_OP)) ? op_ff :
                       (ra == ADDR_W'(ADDR_OPND)) ? opnd_ff :
                       (ra == ADDR_W'(ADDR_PC)) ? 32'(pc_ff) :
                       (ra == ADDR_W'(ADDR_FLAGS)) ? {24'h000000, status_flags_register_ff} :
                       (ra == ADDR_W'(ADDR_STATUS)) ? stat_word : 32'h0000_0000;

  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else begin
      awready_ff <= aw_take;
      wready_ff <= aw_take;
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
      end
      arready_ff <= s_axi_arvalid_i & !arready_ff & !rvalid_ff;
      if (ar_fire) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= is_mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  // ==========================================================
  // assertions
  wire [7:0] k_plus_one = {s_k[6], s_k} + STEP_NEXT;

  property p_eq_skip_two;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && s_opc == OPC_CMP_SKIP_EQ && rd_val == rr_val && s_two |=>
      busy [*3] ##1 (!busy && (pc_ff - $past(pc_ff, 4)) == PC_W'(3));
  endproperty
  a_eq_skip_two: assert property (p_eq_skip_two)
    else $error("equal compare-skip over two words wrong");

  property p_eq_no_skip;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && s_opc == OPC_CMP_SKIP_EQ && rd_val != rr_val |=>
      busy ##1 (!busy && (pc_ff - $past(pc_ff, 2)) == PC_W'(1));
  endproperty
  a_eq_no_skip: assert property (p_eq_no_skip)
    else $error("unequal compare-skip did not step one");

  property p_cmp_flags;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && is_cmp |=> busy ##1 (!busy && status_flags_register_ff[FLAG_C] == $past(alu_c, 2) &&
      status_flags_register_ff[FLAG_Z] == $past(alu_z, 2) && status_flags_register_ff[FLAG_T] == $past(status_flags_register_ff[FLAG_T], 2));
  endproperty
  a_cmp_flags: assert property (p_cmp_flags)
    else $error("compare flags or timing wrong");

  property p_reg_clr_skip;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && s_opc == OPC_SKIP_REG_CLR && !rd_val[s_idx] && !s_two |=>
      busy [*2] ##1 (!busy && (pc_ff - $past(pc_ff, 3)) == PC_W'(2));
  endproperty
  a_reg_clr_skip: assert property (p_reg_clr_skip)
    else $error("register bit clear skip wrong");

  property p_reg_set_noskip;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && s_opc == OPC_SKIP_REG_SET && !rd_val[s_idx] |=> busy ##1 !busy;
  endproperty
  a_reg_set_noskip: assert property (p_reg_set_noskip)
    else $error("register bit set skip took too long");

  property p_io_bits;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && (s_opc == OPC_SKIP_IO_CLR || s_opc == OPC_SKIP_IO_SET) |=>
      taken_ff == ($past(s_opc) == OPC_SKIP_IO_SET ? $past(io_val[s_idx]) : !$past(io_val[s_idx]));
  endproperty
  a_io_bits: assert property (p_io_bits)
    else $error("io bit skip decision wrong");

  property p_flag_set_branch;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && s_opc == OPC_BR_FLAG_SET && status_flags_register_ff[s_idx] |=>
      busy [*2] ##1 (pc_ff == pc_step($past(pc_ff, 3), $past(k_plus_one, 3)));
  endproperty
  a_flag_set_branch: assert property (p_flag_set_branch)
    else $error("flag set branch target wrong");

  property p_flag_clr_untaken;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && s_opc == OPC_BR_FLAG_CLR && status_flags_register_ff[s_idx] |=> busy ##1 !busy;
  endproperty
  a_flag_clr_untaken: assert property (p_flag_clr_untaken)
    else $error("untaken flag clear branch not one cycle");

  property p_zero_branches;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && (s_opc == OPC_BR_EQ || s_opc == OPC_BR_NE) |->
      s_taken == (status_flags_register_ff[FLAG_Z] ^ (s_opc == OPC_BR_NE));
  endproperty
  a_zero_branches: assert property (p_zero_branches)
    else $error("zero flag branch decision wrong");

  property p_signed_branches;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && (s_opc == OPC_BR_SIGNED_GE || s_opc == OPC_BR_SIGNED_LT) |->
      s_taken == (status_flags_register_ff[FLAG_N] ^ status_flags_register_ff[FLAG_V] ^ (s_opc == OPC_BR_SIGNED_GE));
  endproperty
  a_signed_branches: assert property (p_signed_branches)
    else $error("signed branch decision wrong");

  property p_untaken_branch;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && is_branch && !s_cond |=> busy ##1
      (!busy && status_flags_register_ff == $past(status_flags_register_ff, 2) && (pc_ff - $past(pc_ff, 2)) == PC_W'(1));
  endproperty
  a_untaken_branch: assert property (p_untaken_branch)
    else $error("untaken branch changed flags or pc");

  c_skip_three: cover property (@(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && is_skip && s_cond && s_two);
  c_branch_taken: cover property (@(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && is_branch && s_cond);
  c_compare: cover property (@(posedge ref_clk_i) disable iff (!rst_n_ff)
    start && s_opc == OPC_CMP_CARRY);

endmodule
`default_nettype wire

/* File: verif/cssb_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cssb_unit_tb
  import cssb_pkg::*;
;
  logic ref_clk_i;
  logic reset_n_i;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic [31:0] wdata;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  cssb_unit u_cssb_unit (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================
  // bus cycles and comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [31:0] mkop(logic [4:0] o, logic [2:0] i, logic t, logic [6:0] k);
    return {9'h000, k, 3'h0, t, 1'b0, i, 3'h0, o};
  endfunction

  // expected flags of a compare: difference discarded
  function automatic logic [7:0] cmpf(logic [7:0] f, a, b, logic ci, kz);
    logic [8:0] r;
    logic [7:0] o;
    r = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    o = f;
    o[FLAG_C] = r[8];
    o[FLAG_Z] = (r[7:0] == 8'h00) && (!kz || f[FLAG_Z]);
    o[FLAG_N] = r[7];
    o[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    o[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    return o;
  endfunction

  function automatic logic brt(logic [4:0] o, logic [2:0] i, logic [7:0] f);
    case (o)
      OPC_BR_FLAG_SET: return f[i];
      OPC_BR_FLAG_CLR: return !f[i];
      OPC_BR_EQ: return f[FLAG_Z];
      OPC_BR_NE: return !f[FLAG_Z];
      OPC_BR_CARRY_SET, OPC_BR_LOWER: return f[FLAG_C];
      OPC_BR_CARRY_CLR, OPC_BR_SAME_HIGHER: return !f[FLAG_C];
      OPC_BR_MINUS: return f[FLAG_N];
      OPC_BR_PLUS: return !f[FLAG_N];
      OPC_BR_SIGNED_GE: return !(f[FLAG_N] ^ f[FLAG_V]);
      OPC_BR_SIGNED_LT: return f[FLAG_N] ^ f[FLAG_V];
      OPC_BR_HALF_SET: return f[FLAG_H];
      OPC_BR_HALF_CLR: return !f[FLAG_H];
      OPC_BR_XFER_SET: return f[FLAG_T];
      OPC_BR_XFER_CLR: return !f[FLAG_T];
      OPC_BR_OVF_SET: return f[FLAG_V];
      default: return !f[FLAG_V];
    endcase
  endfunction

  // start at pc 0x0100, wait for busy to drop, then judge the outcome
  task automatic run(input logic [31:0] op, od, input logic [7:0] fl, input logic [15:0] epc,
                     input logic [7:0] efl, input logic [1:0] ec, input logic et);
    logic [31:0] v;
    logic [1:0] r;
    wr(ADDR_PC, 32'h0000_0100, r);
    wr(ADDR_FLAGS, 32'(fl), r);
    wr(ADDR_OPND, od, r);
    wr(ADDR_OP, op, r);
    chk("op_resp", 32'(RESP_OKAY), 32'(r));
    do rd(ADDR_STATUS, v, r); while (v[STAT_BUSY_BIT] !== 1'b0);
    chk("cycles", 32'(ec), 32'(v[5:4]));
    if (et !== 1'bx) chk("taken", 32'(et), 32'(v[STAT_TAKEN_BIT]));
    rd(ADDR_PC, v, r);
    chk("pc", 32'(epc), 32'(v[15:0]));
    rd(ADDR_FLAGS, v, r);
    chk("flags", 32'(efl), 32'(v[7:0]));
  endtask

  // ==========================================
  // scenarios
  task automatic t_regs;
    logic [31:0] v;
    logic [1:0] r;
    rd(ADDR_OP, v, r);
    chk("op_reset", OP_RST, v);
    rd(ADDR_FLAGS, v, r);
    chk("flags_reset", 32'(FLAGS_RST), v);
    rd(8'h14, v, r);
    chk("unmapped_rresp", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped_rdata", 32'h0000_0000, v);
    wr(8'h20, 32'h0000_0001, r);
    chk("unmapped_bresp", 32'(RESP_SLVERR), 32'(r));
    wr(ADDR_OP, 32'h0000_001a, r);
    chk("bad_op_bresp", 32'(RESP_SLVERR), 32'(r));
    wr(ADDR_STATUS, 32'h0000_0033, r);
    rd(ADDR_STATUS, v, r);
    chk("status_ro", 32'h0000_0000, 32'(v[STAT_BUSY_BIT]));
    $display("test regs done");
  endtask

  task automatic t_cmp;
    run(mkop(OPC_CMP, 0, 0, 0), 32'h0000_0180, 8'h40, 16'h0101,
        cmpf(8'h40, 8'h80, 8'h01, 0, 0), CYC_ONE, 1'bx);
    run(mkop(OPC_CMP, 0, 0, 0), 32'h0000_2010, 8'h00, 16'h0101,
        cmpf(8'h00, 8'h10, 8'h20, 0, 0), CYC_ONE, 1'bx);
    run(mkop(OPC_CMP_CARRY, 0, 0, 0), 32'h0000_0405, 8'h01, 16'h0101,
        cmpf(8'h01, 8'h05, 8'h04, 1, 1), CYC_ONE, 1'bx);
    run(mkop(OPC_CMP_IMM, 0, 0, 0), 32'h0000_3c3c, 8'hff, 16'h0101,
        cmpf(8'hff, 8'h3c, 8'h3c, 0, 0), CYC_ONE, 1'bx);
    $display("test compare done");
  endtask

  task automatic t_skip;
    logic sk;
    run(mkop(OPC_CMP_SKIP_EQ, 0, 0, 0), 32'h0000_5a5a, 8'h3c, 16'h0102, 8'h3c, CYC_TWO, 1);
    run(mkop(OPC_CMP_SKIP_EQ, 0, 1, 0), 32'h0000_5a5a, 8'h3c, 16'h0103, 8'h3c, CYC_THREE, 1);
    run(mkop(OPC_CMP_SKIP_EQ, 0, 1, 0), 32'h0000_5a5b, 8'h3c, 16'h0101, 8'h3c, CYC_ONE, 0);
    // bit 1 of 0xa5 is clear, bit 2 set; the other source holds the inverse
    for (int o = 4; o < 8; o++) begin
      for (int b = 0; b < 2; b++) begin
        sk = (b == o % 2);
        run(mkop(5'(o), 3'(b + 1), b[0], 0), o > 5 ? 32'h00a5_005a : 32'h005a_00a5, 8'h3c,
            sk ? (b ? 16'h0103 : 16'h0102) : 16'h0101, 8'h3c,
            sk ? (b ? CYC_THREE : CYC_TWO) : CYC_ONE, sk);
      end
    end
    $display("test skip done");
  endtask

  task automatic t_branch;
    logic [7:0] pats [6] = '{8'h00, 8'hff, 8'h08, 8'h04, 8'h55, 8'haa};
    logic tk;
    for (int o = 8; o < 26; o++) begin
      for (int j = 0; j < 6; j++) begin
        tk = brt(5'(o), 3'(j + 2), pats[j]);
        run(mkop(5'(o), 3'(j + 2), 0, 7'h7d), 32'h00a5_a5a5, pats[j], tk ? 16'h00fe : 16'h0101,
            pats[j], tk ? CYC_TWO : CYC_ONE, tk);
      end
    end
    $display("test branch done");
  endtask

  // ==========================================
  // sequence, timeout and verdict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      report_and_stop;
    end
  end

  initial begin
    reset_n_i = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_regs;
    t_cmp;
    t_skip;
    t_branch;
    report_and_stop;
  end
endmodule
`default_nettype wire
